// file: bench/shbrs_partner.sv
// Purpose: far side model: completion return, EEPROM loader, queue flush
// Assumes: answers completions and loads a few cycles after each request, flushes one cycle after
// Notes:   err_i makes the loader report a fault
`timescale 1ns/1ps

module shbrs_partner
	import shbrs_pkg::*;
(
	// clock, reset, command
	input  logic			mclk_i,
	input  logic			rst_n_i,
	input  logic			err_i,
	// requests and answers
	input  logic			cpl_req_i,
	input  logic			load_i,
	input  logic [NUM_DS-1:0]	flush_i,
	output logic			cpl_done_o,
	output logic			eep_done_o,
	output logic			eep_err_o,
	output logic [NUM_DS-1:0]	flush_done_o
);
	logic [2:0]	dly;

	// slow completion and load answers on purpose: the block must wait for them
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dly <= 3'h0;
			cpl_done_o <= 1'b0;
			eep_done_o <= 1'b0;
			eep_err_o <= 1'b0;
			flush_done_o <= '0;
		end
		else
		begin
			dly <= (cpl_req_i || load_i) ? dly + 3'h1 : 3'h0;
			cpl_done_o <= cpl_req_i && dly == 3'h3;
			eep_done_o <= load_i && !err_i && dly == 3'h5;
			eep_err_o <= load_i && err_i && dly == 3'h5;
			flush_done_o <= flush_i;
		end
	end
endmodule

// file: bench/shbrs_seq_properties.sv
// Purpose: port checks for the reset sequencer
// Assumes: one clock domain
// Notes:   step lengths as in the hand-over
`timescale 1ns/1ps

module shbrs_seq_properties
	import shbrs_pkg::*;
(
	// watched ports
	input logic			mclk_i,
	input logic			rst_n_i,
	input logic			ce_i,
	input logic			hot_reset_request_bit_cpl_done_i,
	input logic			hot_reset_request_bit_cpl_req_o,
	input logic			eep_load_o,
	input logic			eep_done_i,
	input logic			eep_err_i,
	input logic [ERR_W-1:0]	eep_err_code_i,
	input logic			eep_halt_wr_i,
	input logic			reset_halt_bit_o,
	input logic			smbus_done_o,
	input logic [ERR_W-1:0]	smbus_err_o,
	input logic			core_rst_o,
	input logic			normal_op_o,
	input logic			smb_reg_hr_i,
	input logic			smb_reg_sbr_i,
	input logic			smb_wr_i,
	input logic			smb_wr_o,
	input logic [DATA_W-1:0]	smb_rdata_o,
	input logic			us_sec_ur_o,
	input logic			ds_regs_rst_o,
	input logic			ds_grace_rst_o,
	input logic [NUM_DS-1:0]	ds_flush_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_ts1_to_flush;
		##100 ds_regs_rst_o ##1 (!ds_regs_rst_o && ds_flush_o == '1);
	endsequence
	sequence s_grace;
		##49 ds_grace_rst_o ##1 !ds_grace_rst_o;
	endsequence

	AST_LOAD_ERR: assert property (
		ce_i && eep_load_o && eep_err_i |=> reset_halt_bit_o && smbus_done_o
		&& smbus_err_o == $past(eep_err_code_i)) else $error("load error not kept");
	AST_LOAD_DONE: assert property (
		ce_i && eep_load_o && eep_done_i && !eep_err_i |=> smbus_done_o && !eep_load_o)
		else $error("done flag missing");
	AST_HALT_SRC: assert property (
		$rose(reset_halt_bit_o) |-> $past(eep_load_o) && ($past(eep_err_i) || $past(eep_halt_wr_i)))
		else $error("halt set without cause");
	AST_HALT_HOLD: assert property (
		reset_halt_bit_o |-> core_rst_o && !normal_op_o) else $error("halt not holding");
	AST_CPL_FIRST: assert property (
		$fell(hot_reset_request_bit_cpl_req_o) |-> $past(hot_reset_request_bit_cpl_done_i)) else $error("no completion");
	AST_SBR_STEPS: assert property (
		$rose(us_sec_ur_o) |-> s_ts1_to_flush) else $error("bus reset steps wrong");
	AST_GRACE_LEN: assert property (
		$rose(ds_grace_rst_o) |-> us_sec_ur_o throughout s_grace)
		else $error("graceful reset length wrong");
	AST_SMB_WR: assert property (
		smb_wr_i && (smb_reg_hr_i && core_rst_o || smb_reg_sbr_i && us_sec_ur_o)
		|-> !smb_wr_o) else $error("blanked write passed");
	AST_SMB_RD: assert property (
		ce_i && smb_reg_sbr_i && us_sec_ur_o |=> smb_rdata_o == '0)
		else $error("blanked read not zero");
endmodule

bind shbrs_seq shbrs_seq_properties u_props (.*);

// file: bench/shbrs_seq_tb_top.sv
// Purpose: directed bench for the reset sequencer
// Assumes: ce_i high except for a few cycles in the downstream bus reset test, EEPROM mode on
// Notes:   partner model answers completions, loads and flushes
`timescale 1ns/1ps

module shbrs_seq_tb_top
	import shbrs_pkg::*;
;
	logic	mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, link_down_hotrst_dis_i = 1'b0;
	logic	us_ts1_hot_i = 1'b0, us_dl_down_i = 1'b0, hot_reset_request_bit_i = 1'b0;
	logic	eeprom_mode_i = 1'b1, hot_reset_eeprom_load_disable_i = 1'b0, eep_halt_wr_i = 1'b0;
	logic	smb_halt_clr_i = 1'b0, smb_done_clr_i = 1'b0, smb_reg_hr_i = 1'b0, load_fail = 1'b0;
	logic	smb_reg_sbr_i = 1'b0, smb_wr_i = 1'b0, us_secondary_bus_reset_bit_i = 1'b0;
	logic	hot_reset_request_bit_cpl_done_i, eep_done_i, eep_err_i, hot_reset_request_bit_cpl_req_o, eep_load_o, smbus_done_o;
	logic	reset_halt_bit_o, core_rst_o, normal_op_o, smb_wr_o, us_sec_ur_o;
	logic	ds_regs_rst_o, ds_grace_rst_o;
	logic [ERR_W-1:0]	eep_err_code_i = 4'h0, smbus_err_o;
	logic [DATA_W-1:0]	smb_rdata_i = 32'h5A5AC3C3, smb_rdata_o;
	logic [NUM_DS-1:0]	ds_secondary_bus_reset_bit_i = 2'h0, ds_link_up_i = 2'h3, seen;
	logic [NUM_DS-1:0]	ds_flush_done_i, ds_ts1_hot_o, ds_flush_o, ds_sec_ur_o;
	int			num_errors = 0, checked = 0, cycles = 0;

	shbrs_partner u_partner (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .err_i(load_fail),
		.cpl_req_i(hot_reset_request_bit_cpl_req_o), .load_i(eep_load_o), .flush_i(ds_flush_o),
		.cpl_done_o(hot_reset_request_bit_cpl_done_i), .eep_done_o(eep_done_i), .eep_err_o(eep_err_i),
		.flush_done_o(ds_flush_done_i));
	shbrs_seq u_dut (.*);

	always #5 mclk_i = ~mclk_i;

	// a hung handshake ends the run here
	always @(posedge mclk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic nc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic t_hot_write();
		@(posedge mclk_i);
		hot_reset_request_bit_i <= 1'b1;
		@(posedge mclk_i);
		hot_reset_request_bit_i <= 1'b0;
		nc(1);
		chk(hot_reset_request_bit_cpl_req_o, 1'b1);
		chk(ds_ts1_hot_o, 2'h0);
		while (hot_reset_request_bit_cpl_req_o) nc(1);
		chk(ds_ts1_hot_o, 2'h3);
		while (!eep_load_o) nc(1);
		chk(core_rst_o, 1'b1);
		@(posedge mclk_i);
		smb_reg_hr_i <= 1'b1;
		smb_wr_i <= 1'b1;
		nc(1);
		chk(smb_wr_o, 1'b0);
		nc(1);
		chk(smb_rdata_o, 32'h0);
		@(posedge mclk_i);
		smb_reg_hr_i <= 1'b0;
		smb_wr_i <= 1'b0;
		while (eep_load_o) nc(1);
		chk(smbus_done_o, 1'b1);
		chk(reset_halt_bit_o, 1'b0);
		nc(2);
		chk(normal_op_o, 1'b1);
		chk(smb_rdata_o, 32'h5A5AC3C3);
		@(posedge mclk_i);
		smb_done_clr_i <= 1'b1;
		@(posedge mclk_i);
		smb_done_clr_i <= 1'b0;
	endtask

	// halt written by the EEPROM contents on a clean load
	task automatic t_hot_eep_halt();
		@(posedge mclk_i);
		us_ts1_hot_i <= 1'b1;
		@(posedge mclk_i);
		us_ts1_hot_i <= 1'b0;
		while (!eep_load_o) nc(1);
		chk(smbus_done_o, 1'b0);
		@(posedge mclk_i);
		eep_halt_wr_i <= 1'b1;
		@(posedge mclk_i);
		eep_halt_wr_i <= 1'b0;
		nc(1);
		chk(reset_halt_bit_o, 1'b1);
		while (eep_load_o) nc(1);
		chk(smbus_done_o, 1'b1);
		chk(smbus_err_o, 4'h0);
		nc(5);
		chk(core_rst_o, 1'b1);
		@(posedge mclk_i);
		smb_halt_clr_i <= 1'b1;
		smb_done_clr_i <= 1'b1;
		@(posedge mclk_i);
		smb_halt_clr_i <= 1'b0;
		smb_done_clr_i <= 1'b0;
		nc(3);
		chk(normal_op_o, 1'b1);
		chk(smbus_done_o, 1'b0);
	endtask

	task automatic t_hot_fault();
		@(posedge mclk_i);
		load_fail <= 1'b1;
		eep_err_code_i <= 4'hA;
		us_ts1_hot_i <= 1'b1;
		@(posedge mclk_i);
		us_ts1_hot_i <= 1'b0;
		nc(1);
		chk(smbus_done_o, 1'b0);
		while (!eep_load_o) nc(1);
		while (eep_load_o) nc(1);
		chk(reset_halt_bit_o, 1'b1);
		chk(smbus_err_o, 4'hA);
		chk(smbus_done_o, 1'b1);
		nc(20);
		chk(core_rst_o, 1'b1);
		@(posedge mclk_i);
		smb_halt_clr_i <= 1'b1;
		load_fail <= 1'b0;
		@(posedge mclk_i);
		smb_halt_clr_i <= 1'b0;
		nc(3);
		chk(normal_op_o, 1'b1);
	endtask

	task automatic t_hot_noload();
		seen = 2'h0;
		// a masked link-down must not start anything
		@(posedge mclk_i);
		link_down_hotrst_dis_i <= 1'b1;
		us_dl_down_i <= 1'b1;
		@(posedge mclk_i);
		link_down_hotrst_dis_i <= 1'b0;
		us_dl_down_i <= 1'b0;
		nc(2);
		chk(ds_ts1_hot_o, 2'h0);
		@(posedge mclk_i);
		hot_reset_eeprom_load_disable_i <= 1'b1;
		us_dl_down_i <= 1'b1;
		@(posedge mclk_i);
		us_dl_down_i <= 1'b0;
		repeat (200)
		begin
			nc(1);
			seen = seen | {core_rst_o, eep_load_o};
		end
		chk(seen, 2'h2);
		@(posedge mclk_i);
		hot_reset_eeprom_load_disable_i <= 1'b0;
	endtask

	task automatic t_us_bus_reset();
		@(posedge mclk_i);
		us_secondary_bus_reset_bit_i <= 1'b1;
		nc(2);
		chk(us_sec_ur_o, 1'b1);
		chk(ds_ts1_hot_o, 2'h3);
		nc(100);
		chk(ds_regs_rst_o, 1'b1);
		nc(1);
		chk(ds_flush_o, 2'h3);
		while (!ds_grace_rst_o) nc(1);
		@(posedge mclk_i);
		smb_reg_sbr_i <= 1'b1;
		smb_wr_i <= 1'b1;
		nc(2);
		chk(smb_wr_o, 1'b0);
		chk(smb_rdata_o, 32'h0);
		nc(60);
		chk(ds_grace_rst_o, 1'b0);
		chk(us_sec_ur_o, 1'b1);
		chk(core_rst_o, 1'b0);
		@(posedge mclk_i);
		smb_reg_sbr_i <= 1'b0;
		smb_wr_i <= 1'b0;
		us_secondary_bus_reset_bit_i <= 1'b0;
		nc(3);
		chk(us_sec_ur_o, 1'b0);
	endtask

	task automatic t_ds_bus_reset();
		seen = 2'h0;
		@(posedge mclk_i);
		ds_link_up_i <= 2'h1;
		ds_secondary_bus_reset_bit_i <= 2'h2;
		nc(2);
		chk(ds_sec_ur_o, 2'h2);
		chk(ds_ts1_hot_o, 2'h0);
		chk(us_sec_ur_o, 1'b0);
		@(posedge mclk_i);
		ds_link_up_i <= 2'h3;
		nc(1);
		chk(ds_ts1_hot_o, 2'h2);
		repeat (110)
		begin
			nc(1);
			seen = seen | ds_flush_o;
		end
		chk(seen, 2'h2);
		chk(ds_sec_ur_o, 2'h2);
		chk(core_rst_o, 1'b0);
		// clock enable low must freeze the wait state
		@(posedge mclk_i);
		ce_i <= 1'b0;
		ds_secondary_bus_reset_bit_i <= 2'h0;
		nc(3);
		chk(ds_sec_ur_o, 2'h2);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		nc(2);
		chk(ds_sec_ur_o, 2'h0);
	endtask

	// reset in the middle of a bus reset, bit dropped with it
	task automatic t_mid_reset();
		@(posedge mclk_i);
		us_secondary_bus_reset_bit_i <= 1'b1;
		nc(3);
		chk(us_sec_ur_o, 1'b1);
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		us_secondary_bus_reset_bit_i <= 1'b0;
		nc(1);
		chk(us_sec_ur_o, 1'b0);
		chk(normal_op_o, 1'b1);
		@(posedge mclk_i);
		rst_n_i <= 1'b1;
		nc(2);
		chk(us_sec_ur_o, 1'b0);
		chk(ds_ts1_hot_o, 2'h0);
	endtask

	initial
	begin
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_hot_write();
		t_hot_eep_halt();
		t_hot_fault();
		t_hot_noload();
		t_us_bus_reset();
		t_ds_bus_reset();
		t_mid_reset();
		final_report();
	end
endmodule

// file: core/shbrs_seq.sv
// Purpose: hot reset tail, upstream and downstream secondary bus reset sequencing
// Assumes: all inputs come from logic on mclk_i; EEPROM loader and queues are external
// Notes:   control and status bits are plain ports, there is no register bus here
`timescale 1ns/1ps

module shbrs_seq
	import shbrs_pkg::*;
(
	// clock, reset, enable
	input  wire logic                     mclk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     ce_i,
	// hot reset triggers
	input  wire logic                     us_ts1_hot_i,
	input  wire logic                     us_dl_down_i,
	input  wire logic                     link_down_hotrst_dis_i,
	input  wire logic                     hot_reset_request_bit_i,
	input  wire logic                     hot_reset_request_bit_cpl_done_i,
	output logic                          hot_reset_request_bit_cpl_req_o,
	// serial EEPROM loader
	input  wire logic                     eeprom_mode_i,
	input  wire logic                     hot_reset_eeprom_load_disable_i,
	input  wire logic                     eep_done_i,
	input  wire logic                     eep_err_i,
	input  wire logic [ERR_W-1:0]         eep_err_code_i,
	input  wire logic                     eep_halt_wr_i,
	output logic                          eep_load_o,
	// status bits
	input  wire logic                     smb_halt_clr_i,
	input  wire logic                     smb_done_clr_i,
	output logic                          reset_halt_bit_o,
	output logic                          smbus_done_o,
	output logic [ERR_W-1:0]              smbus_err_o,
	output logic                          core_rst_o,
	output logic                          normal_op_o,
	// slave SMBus register access
	input  wire logic                     smb_reg_hr_i,
	input  wire logic                     smb_reg_sbr_i,
	input  wire logic                     smb_wr_i,
	input  wire logic [DATA_W-1:0]        smb_rdata_i,
	output logic                          smb_wr_o,
	output logic [DATA_W-1:0]             smb_rdata_o,
	// upstream secondary bus reset
	input  wire logic                     us_secondary_bus_reset_bit_i,
	output logic                          us_sec_ur_o,
	output logic                          ds_regs_rst_o,
	output logic                          ds_grace_rst_o,
	// downstream ports
	input  wire logic [NUM_DS-1:0]        ds_secondary_bus_reset_bit_i,
	input  wire logic [NUM_DS-1:0]        ds_link_up_i,
	input  wire logic [NUM_DS-1:0]        ds_flush_done_i,
	output logic [NUM_DS-1:0]             ds_ts1_hot_o,
	output logic [NUM_DS-1:0]             ds_flush_o,
	output logic [NUM_DS-1:0]             ds_sec_ur_o
);

	shbrs_state_t q;
	shbrs_state_t next_q;
	logic         hr_trig;
	logic         us_rise;
	logic         blank;

	// ****************************************
	// shared terms
	// ****************************************
	// link-down trigger can be masked, the others cannot
	assign hr_trig = us_ts1_hot_i | (us_dl_down_i & ~link_down_hotrst_dis_i);
	assign us_rise = us_secondary_bus_reset_bit_i & ~q.us_secondary_bus_reset_bit_q;
	// registers cleared by a running reset read zero and drop writes
	assign blank   = (smb_reg_hr_i & (q.hr != HR_IDLE) & (q.hr != HR_CPL))
		| (smb_reg_sbr_i & (q.sb != SB_IDLE));

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_q             = q;
		next_q.us_secondary_bus_reset_bit_q = us_secondary_bus_reset_bit_i;
		next_q.ds_secondary_bus_reset_bit_q = ds_secondary_bus_reset_bit_i;
		next_q.smb_rdata   = blank ? '0 : smb_rdata_i;

		// clears first so that a same-cycle set wins
		if (smb_halt_clr_i)
		begin
			next_q.halt = 1'b0;
		end
		if (smb_done_clr_i)
		begin
			next_q.done = 1'b0;
		end

		unique case (q.hr)
			HR_IDLE:
			begin
				if (hr_trig)
				begin
					next_q.hr     = HR_TS1;
					next_q.hr_cnt = TS1_CYC - 1'b1;
				end
				else if (hot_reset_request_bit_i)
				begin
					next_q.hr = HR_CPL;
				end
			end
			HR_CPL:
			begin
				// the write's completion leaves before anything is reset, unless hr_trig arrives first
				if (hot_reset_request_bit_cpl_done_i | hr_trig)
				begin
					next_q.hr     = HR_TS1;
					next_q.hr_cnt = TS1_CYC - 1'b1;
				end
			end
			HR_TS1:
			begin
				if (q.hr_cnt == '0)
				begin
					next_q.hr     = HR_RESET;
					next_q.hr_cnt = CORE_RST_CYC - 1'b1;
				end
				else
				begin
					next_q.hr_cnt = q.hr_cnt - 1'b1;
				end
			end
			HR_RESET:
			begin
				// a hot reset also ends any bus reset in progress
				next_q.sb = SB_IDLE;
				next_q.ds = '{default: DS_IDLE};
				if (q.hr_cnt == '0)
				begin
					if (eeprom_mode_i & ~hot_reset_eeprom_load_disable_i)
					begin
						next_q.hr = HR_EEP;
					end
					else
					begin
						next_q.hr = HR_HALT;
					end
				end
				else
				begin
					next_q.hr_cnt = q.hr_cnt - 1'b1;
				end
			end
			HR_EEP:
			begin
				if (eep_halt_wr_i)
				begin
					next_q.halt = 1'b1;
				end
				if (eep_err_i)
				begin
					next_q.halt = 1'b1;
					next_q.err  = eep_err_code_i;
					next_q.done = 1'b1;
					next_q.hr   = HR_HALT;
				end
				else if (eep_done_i)
				begin
					next_q.done = 1'b1;
					next_q.hr   = HR_HALT;
				end
			end
			HR_HALT:
			begin
				if (~q.halt)
				begin
					next_q.hr = HR_IDLE;
				end
			end
			default:
			begin
				next_q.hr = HR_IDLE;
			end
		endcase

		if (q.hr == HR_IDLE)
		begin
			unique case (q.sb)
				SB_IDLE:
				begin
					if (us_rise)
					begin
						next_q.sb     = SB_TS1;
						next_q.sb_cnt = TS1_CYC - 1'b1;
					end
				end
				SB_TS1:
				begin
					if (q.sb_cnt == '0)
					begin
						next_q.sb = SB_REGRST;
					end
					else
					begin
						next_q.sb_cnt = q.sb_cnt - 1'b1;
					end
				end
				SB_REGRST:
				begin
					// port-local bus resets are part of what gets cleared
					next_q.ds = '{default: DS_IDLE};
					next_q.sb = SB_FLUSH;
				end
				SB_FLUSH:
				begin
					if (&ds_flush_done_i)
					begin
						next_q.sb     = SB_GRACE;
						next_q.sb_cnt = GRACE_CYC - 1'b1;
					end
				end
				SB_GRACE:
				begin
					if (q.sb_cnt == '0)
					begin
						next_q.sb = SB_WAIT;
					end
					else
					begin
						next_q.sb_cnt = q.sb_cnt - 1'b1;
					end
				end
				SB_WAIT:
				begin
					if (~us_secondary_bus_reset_bit_i)
					begin
						next_q.sb = SB_IDLE;
					end
				end
				default:
				begin
					next_q.sb = SB_IDLE;
				end
			endcase

			// each port only ever touches its own slot
			for (int i = 0; i < NUM_DS; i++)
			begin
				if (q.sb != SB_REGRST)
				begin
					unique case (q.ds[i])
						DS_IDLE:
						begin
							if (ds_secondary_bus_reset_bit_i[i] & ~q.ds_secondary_bus_reset_bit_q[i])
							begin
								next_q.ds[i]     = DS_TS1;
								next_q.ds_cnt[i] = TS1_CYC - 1'b1;
							end
						end
						DS_TS1:
						begin
							if (q.ds_cnt[i] == '0)
							begin
								next_q.ds[i] = DS_FLUSH;
							end
							else
							begin
								next_q.ds_cnt[i] = q.ds_cnt[i] - 1'b1;
							end
						end
						DS_FLUSH:
						begin
							if (ds_flush_done_i[i])
							begin
								next_q.ds[i] = DS_WAIT;
							end
						end
						DS_WAIT:
						begin
							if (~ds_secondary_bus_reset_bit_i[i])
							begin
								next_q.ds[i] = DS_IDLE;
							end
						end
						default:
						begin
							next_q.ds[i] = DS_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= ST_RESET;
		end
		else if (ce_i)
		begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hot_reset_request_bit_cpl_req_o   = (q.hr == HR_CPL);
	assign eep_load_o       = (q.hr == HR_EEP);
	assign reset_halt_bit_o = q.halt;
	assign smbus_done_o     = q.done;
	assign smbus_err_o      = q.err;
	// SMBus and the upstream link stay out of this reset
	assign core_rst_o       = (q.hr == HR_RESET) | (q.hr == HR_EEP)
		| (q.hr == HR_HALT) | q.halt;
	assign normal_op_o      = (q.hr == HR_IDLE) & ~q.halt;
	assign smb_wr_o         = smb_wr_i & ~blank;
	assign smb_rdata_o      = q.smb_rdata;
	assign us_sec_ur_o      = (q.sb != SB_IDLE);
	assign ds_regs_rst_o    = (q.sb == SB_REGRST);
	assign ds_grace_rst_o   = (q.sb == SB_GRACE);

	genvar g;
	generate
		for (g = 0; g < NUM_DS; g++)
		begin : g_port
			assign ds_ts1_hot_o[g] = ds_link_up_i[g] & ((q.hr == HR_TS1)
				| (q.sb == SB_TS1) | (q.ds[g] == DS_TS1));
			assign ds_flush_o[g]   = (q.sb == SB_FLUSH) | (q.ds[g] == DS_FLUSH);
			assign ds_sec_ur_o[g]  = (q.ds[g] != DS_IDLE);
		end
	endgenerate

endmodule

// file: include/shbrs_pkg.sv
// Purpose: constants and types for the hot reset and secondary bus reset sequencer
// Assumes: core clock of 100 MHz; one upstream port and two downstream ports
// Notes:   the module registers one state struct; its reset value lives here

package shbrs_pkg;

	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int          NUM_DS       = 2;
	localparam int          CNT_W        = 8;
	localparam int          ERR_W        = 4;
	localparam int          DATA_W       = 32;
	localparam int          CLK_MHZ      = 100;
	localparam int          TS1_NS       = 1000;
	localparam int          CORE_RST_NS  = 200;
	localparam int          GRACE_NS     = 500;
	localparam logic [CNT_W-1:0] TS1_CYC      = CNT_W'((TS1_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CORE_RST_CYC = CNT_W'((CORE_RST_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] GRACE_CYC    = CNT_W'((GRACE_NS * CLK_MHZ + 999) / 1000);

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [5:0] {
		HR_IDLE  = 6'h01,
		HR_CPL   = 6'h02,
		HR_TS1   = 6'h04,
		HR_RESET = 6'h08,
		HR_EEP   = 6'h10,
		HR_HALT  = 6'h20
	} shbrs_hr_t;

	typedef enum logic [5:0] {
		SB_IDLE   = 6'h01,
		SB_TS1    = 6'h02,
		SB_REGRST = 6'h04,
		SB_FLUSH  = 6'h08,
		SB_GRACE  = 6'h10,
		SB_WAIT   = 6'h20
	} shbrs_sb_t;

	typedef enum logic [3:0] {
		DS_IDLE  = 4'h1,
		DS_TS1   = 4'h2,
		DS_FLUSH = 4'h4,
		DS_WAIT  = 4'h8
	} shbrs_ds_t;

	typedef struct packed {
		shbrs_hr_t                     hr;
		logic [CNT_W-1:0]              hr_cnt;
		shbrs_sb_t                     sb;
		logic [CNT_W-1:0]              sb_cnt;
		shbrs_ds_t [NUM_DS-1:0]        ds;
		logic [NUM_DS-1:0][CNT_W-1:0]  ds_cnt;
		logic                          us_secondary_bus_reset_bit_q;
		logic [NUM_DS-1:0]             ds_secondary_bus_reset_bit_q;
		logic                          halt;
		logic                          done;
		logic [ERR_W-1:0]              err;
		logic [DATA_W-1:0]             smb_rdata;
	} shbrs_state_t;

	localparam shbrs_state_t ST_RESET = '{
		hr:          HR_IDLE,
		hr_cnt:      '0,
		sb:          SB_IDLE,
		sb_cnt:      '0,
		ds:          '{default: DS_IDLE},
		ds_cnt:      '0,
		us_secondary_bus_reset_bit_q: 1'b0,
		ds_secondary_bus_reset_bit_q: '0,
		halt:        1'b0,
		done:        1'b0,
		err:         '0,
		smb_rdata:   '0
	};

endpackage
